// ===== logic/lcd_port_map.svh
// constants of the character display instruction port
`ifndef LCD_PORT_MAP_SVH
`define LCD_PORT_MAP_SVH
// execution times at the reference oscillator in ns, then the reference rate in kHz and the clock period in ns
`define T_SHORT_NS     39000
`define T_DATA_NS      43000
`define T_LONG_NS      1530000
`define OSC_REF_KHZ    270
`define CLK_NS         100
// instruction bit positions
`define BIT_BUSY       7
`define BIT_STEP_UP    1
`define BIT_SCR_SHIFT  0
`define BIT_SCREEN_ON  2
`define BIT_CURSOR_ON  1
`define BIT_BLINK      0
`define BIT_SHIFT_TGT  3
`define BIT_SHIFT_DIR  2
`define BIT_BUS_WIDTH  4
`define BIT_LINES      3
`define BIT_GLYPH_H    2
// address map of the text and glyph memories
`define ADDR_HOME      7'h00
`define LINE1_LAST     7'h27
`define LINE2_FIRST    7'h40
`define LINE2_LAST     7'h67
`define ONE_LINE_LAST  7'h4f
`define SPACE_CODE     8'h20
`define TEXT_DEPTH     128
`define GLYPH_DEPTH    64
`endif

// ===== logic/lcd_port_pkg.sv
// types of the character display instruction port
`include "lcd_port_map.svh"
package lcd_port_pkg;
    // decoded instruction classes
    typedef enum logic [2:0] {
        OP_CLEAR, OP_HOME, OP_ENTRY, OP_DISPLAY,
        OP_SHIFT, OP_FUNC, OP_GLYPH_ADDR, OP_TEXT_ADDR
    } op_t;

    // whole state of the port, registered as one word
    typedef struct packed {
        logic                               rs_s1, rs_s2, rw_s1, rw_s2;
        logic                               en_s1, en_s2, en_s3;
        logic [7:0]                         dat_s1, dat_s2;
        logic [15:0]                        wait_cnt;
        logic                               busy;
        logic [6:0]                         ptr;
        logic                               glyph_sel, step_up, scr_shift;
        logic                               screen_on, cursor_on, cursor_blink;
        logic                               wide_bus, two_line, tall_glyph;
        logic [6:0]                         shift_ofs;
        logic [7:0]                         read_word;
        logic                               second_half;
        logic [3:0]                         hold_nib;
        logic [7:0]                         dout;
        logic                               doe;
        logic [`TEXT_DEPTH-1:0][7:0]        text_ram;
        logic [`GLYPH_DEPTH-1:0][7:0]       glyph_ram;
    } port_state_t;
endpackage

// ===== logic/lcd_port.sv
// instruction port of a character display controller
//
// Behaviour
// - data read returns word from selected RAM
// - read without address set returns stale word
// - cursor shift reloads the text read word
// - pointer steps after each data read
// - display shift after glyph read unreliable
// - write steps pointer; read shows old word
// - clear fills spaces, pointer zero, long time
// - home zeroes pointer and shift, long time
// - entry mode sets direction and screen shift
// - display control sets screen, cursor, blink
// - shift moves cursor or display, RAM untouched
// - function set selects bus width
// - line count and glyph height bits
// - glyph address set loads six-bit pointer
// - text address set loads seven-bit pointer
// - status read shows busy and pointer
// - data write stores word at pointer
// - wide bus moves word per strobe
// - narrow bus moves high then low nibble
// - busy rises only after second nibble
// - width bit one wide, zero narrow
// - text write with screen shift shifts display
// - shift target picks cursor or display
// - two-line text addresses wrap between lines
`include "lcd_port_map.svh"
module lcd_port
    import lcd_port_pkg::*;
#(
    parameter int unsigned OSC_KHZ  = `OSC_REF_KHZ,        // actual oscillator rate
    parameter int unsigned LONG_CYC =
        `T_LONG_NS * `OSC_REF_KHZ / (`OSC_REF_KHZ * `CLK_NS) // clear and home time
) (
    input  wire  logic       clk_in,            // 10 MHz clock
    input  wire  logic       rst_in,            // synchronous reset, high
    input  wire  logic       register_select_in,// high selects data
    input  wire  logic       read_write_in,     // high reads
    input  wire  logic       strobe_in,         // transfer strobe
    input  wire  logic [7:0] data_in,           // data lines, pin level
    output logic       [7:0] data_out,          // data lines, driven value
    output logic             data_oe_out,       // high while driving
    output logic             busy_out,          // internal_op_flag
    output logic       [6:0] ram_pointer_out,   // current pointer
    output logic             screen_on_out,     // screen enabled
    output logic             cursor_on_out,     // cursor shown
    output logic             cursor_blink_out,  // cursor blinks
    output logic             wide_bus_out,      // eight-line transfers
    output logic             two_line_out,      // two display lines
    output logic             tall_glyph_out,    // 5x10 glyphs
    output logic       [6:0] shift_ofs_out      // whole-screen shift offset
);
    // scaled execution times; floor keeps busy no longer than documented
    localparam int unsigned SHORT_CYC =
        `T_SHORT_NS * `OSC_REF_KHZ / (OSC_KHZ * `CLK_NS);
    localparam int unsigned DATA_CYC  =
        `T_DATA_NS * `OSC_REF_KHZ / (OSC_KHZ * `CLK_NS);

    // refuse counts that the 16-bit busy counter cannot hold
    if (OSC_KHZ == 0 || SHORT_CYC == 0 || LONG_CYC == 0 || LONG_CYC > 65535
        || DATA_CYC > 65535) begin : g_bad_counts
        $error("lcd_port: execution counts out of range");
    end

    port_state_t st_reg;
    port_state_t st_next;
    logic        rise_edge;
    logic        fall_edge;
    logic        word_done;
    logic        exec;
    logic [7:0]  word;
    op_t         op;

    // classify an instruction code by its leading one
    function automatic op_t decode(input logic [7:0] c);
        op_t r;
        if (c[7])      r = OP_TEXT_ADDR;
        else if (c[6]) r = OP_GLYPH_ADDR;
        else if (c[5]) r = OP_FUNC;
        else if (c[4]) r = OP_SHIFT;
        else if (c[3]) r = OP_DISPLAY;
        else if (c[2]) r = OP_ENTRY;
        else if (c[1]) r = OP_HOME;
        else           r = OP_CLEAR;
        return r;
    endfunction

    // step the pointer one place, honouring line wrap of the text memory
    function automatic logic [6:0] step_ptr(input logic [6:0] a, input logic up,
                                            input logic two, input logic glyph);
        logic [6:0] r;
        logic [5:0] g;
        r = up ? a + 7'h01 : a - 7'h01;
        g = up ? a[5:0] + 6'h01 : a[5:0] - 6'h01;
        if (glyph) begin
            r = {1'b0, g};
        end else if (two) begin
            if (up && a == `LINE1_LAST)          r = `LINE2_FIRST;
            else if (up && a == `LINE2_LAST)     r = `ADDR_HOME;
            else if (!up && a == `LINE2_FIRST)   r = `LINE1_LAST;
            else if (!up && a == `ADDR_HOME)     r = `LINE2_LAST;
        end else begin
            if (up && a == `ONE_LINE_LAST)       r = `ADDR_HOME;
            else if (!up && a == `ADDR_HOME)     r = `ONE_LINE_LAST;
        end
        return r;
    endfunction

    // shift the visible window one column within a 40-column line
    function automatic logic [6:0] shift_win(input logic [6:0] o, input logic left);
        logic [6:0] r;
        if (left) r = (o == `LINE1_LAST) ? `ADDR_HOME : o + 7'h01;
        else      r = (o == `ADDR_HOME) ? `LINE1_LAST : o - 7'h01;
        return r;
    endfunction

    // memory word at an address of the selected memory
    function automatic logic [7:0] ram_at(input port_state_t s, input logic [6:0] a);
        return s.glyph_sel ? s.glyph_ram[a[5:0]] : s.text_ram[a];
    endfunction

    // strobe edges come from the second and third stage only
    assign rise_edge = st_reg.en_s2 && !st_reg.en_s3;
    assign fall_edge = !st_reg.en_s2 && st_reg.en_s3;
    assign word_done = fall_edge && (st_reg.wide_bus || st_reg.second_half);
    assign word      = st_reg.wide_bus ? st_reg.dat_s2
                                       : {st_reg.hold_nib, st_reg.dat_s2[7:4]};
    // a word executes unless a status read or the device is busy
    assign exec      = word_done && !st_reg.busy
                       && (st_reg.rs_s2 || !st_reg.rw_s2);
    assign op        = decode(word);

    // next state of the whole port
    always_comb begin
        logic [7:0] shown;
        logic [6:0] np;
        shown   = 8'h00;
        np      = st_reg.ptr;
        st_next = st_reg;
        // pin synchronisers; first stages feed only second stages
        st_next.rs_s1  = register_select_in;
        st_next.rs_s2  = st_reg.rs_s1;
        st_next.rw_s1  = read_write_in;
        st_next.rw_s2  = st_reg.rw_s1;
        st_next.en_s1  = strobe_in;
        st_next.en_s2  = st_reg.en_s1;
        st_next.en_s3  = st_reg.en_s2;
        st_next.dat_s1 = data_in;
        st_next.dat_s2 = st_reg.dat_s1;
        // busy counter
        if (st_reg.wait_cnt != 16'h0000) begin
            st_next.wait_cnt = st_reg.wait_cnt - 16'h0001;
        end
        // read cycle: drive while the strobe is high
        if (rise_edge && st_reg.rw_s2) begin
            shown = st_reg.rs_s2 ? st_reg.read_word
                                 : {st_reg.busy, st_reg.ptr};
            st_next.doe  = 1'b1;
            st_next.dout = (st_reg.wide_bus || !st_reg.second_half) ? shown
                           : {shown[3:0], 4'h0};
        end
        if (fall_edge) begin
            st_next.doe = 1'b0;
            if (!st_reg.wide_bus) begin
                st_next.second_half = !st_reg.second_half;
                st_next.hold_nib    = st_reg.dat_s2[7:4];
            end
        end
        // instruction and data execution
        if (exec) begin
            st_next.wait_cnt = 16'(SHORT_CYC);
            if (st_reg.rs_s2 && st_reg.rw_s2) begin
                np                = step_ptr(st_reg.ptr, st_reg.step_up,
                                             st_reg.two_line, st_reg.glyph_sel);
                st_next.ptr       = np;
                st_next.read_word = ram_at(st_reg, np);
                st_next.wait_cnt  = 16'(DATA_CYC);
            end else if (st_reg.rs_s2) begin
                if (st_reg.glyph_sel) begin
                    st_next.glyph_ram[st_reg.ptr[5:0]] = word;
                end else begin
                    st_next.text_ram[st_reg.ptr] = word;
                    if (st_reg.scr_shift) begin
                        st_next.shift_ofs = shift_win(st_reg.shift_ofs,
                                                      st_reg.step_up);
                    end
                end
                // read word is not refreshed, so a read shows the older word
                st_next.ptr      = step_ptr(st_reg.ptr, st_reg.step_up,
                                            st_reg.two_line, st_reg.glyph_sel);
                st_next.wait_cnt = 16'(DATA_CYC);
            end else begin
                unique case (op)
                    OP_CLEAR: begin
                        for (int i = 0; i < `TEXT_DEPTH; i++) begin
                            st_next.text_ram[i] = `SPACE_CODE;
                        end
                        st_next.ptr       = `ADDR_HOME;
                        st_next.glyph_sel = 1'b0;
                        st_next.step_up   = 1'b1;
                        st_next.shift_ofs = `ADDR_HOME;
                        st_next.wait_cnt  = 16'(LONG_CYC);
                    end
                    OP_HOME: begin
                        st_next.ptr       = `ADDR_HOME;
                        st_next.glyph_sel = 1'b0;
                        st_next.shift_ofs = `ADDR_HOME;
                        st_next.wait_cnt  = 16'(LONG_CYC);
                    end
                    OP_ENTRY: begin
                        st_next.step_up   = word[`BIT_STEP_UP];
                        st_next.scr_shift = word[`BIT_SCR_SHIFT];
                    end
                    OP_DISPLAY: begin
                        st_next.screen_on    = word[`BIT_SCREEN_ON];
                        st_next.cursor_on    = word[`BIT_CURSOR_ON];
                        st_next.cursor_blink = word[`BIT_BLINK];
                    end
                    OP_SHIFT: begin
                        // after a glyph read this shift is not guaranteed
                        if (word[`BIT_SHIFT_TGT]) begin
                            st_next.shift_ofs = shift_win(st_reg.shift_ofs,
                                                          !word[`BIT_SHIFT_DIR]);
                        end else begin
                            np = step_ptr(st_reg.ptr, word[`BIT_SHIFT_DIR],
                                          st_reg.two_line, st_reg.glyph_sel);
                            st_next.ptr = np;
                            if (!st_reg.glyph_sel) begin
                                st_next.read_word = st_reg.text_ram[np];
                            end
                        end
                    end
                    OP_FUNC: begin
                        st_next.wide_bus   = word[`BIT_BUS_WIDTH];
                        st_next.two_line   = word[`BIT_LINES];
                        st_next.tall_glyph = word[`BIT_GLYPH_H];
                    end
                    OP_GLYPH_ADDR: begin
                        st_next.glyph_sel = 1'b1;
                        st_next.ptr       = {1'b0, word[5:0]};
                        st_next.read_word = st_reg.glyph_ram[word[5:0]];
                    end
                    OP_TEXT_ADDR: begin
                        st_next.glyph_sel = 1'b0;
                        st_next.ptr       = word[6:0];
                        st_next.read_word = st_reg.text_ram[word[6:0]];
                    end
                endcase
            end
        end
        // flag follows the counter, so it rises only once a word is whole
        st_next.busy = (st_next.wait_cnt != 16'h0000);
        if (rst_in) begin
            st_next              = '0;
            st_next.wide_bus     = 1'b1;
            st_next.step_up      = 1'b1;
            st_next.read_word    = `SPACE_CODE;
        end
    end

    // single state register, reset folded into the next value
    always_ff @(posedge clk_in) begin
        st_reg <= st_next;
    end

    assign data_out         = st_reg.dout;
    assign data_oe_out      = st_reg.doe;
    assign busy_out         = st_reg.busy;
    assign ram_pointer_out  = st_reg.ptr;
    assign screen_on_out    = st_reg.screen_on;
    assign cursor_on_out    = st_reg.cursor_on;
    assign cursor_blink_out = st_reg.cursor_blink;
    assign wide_bus_out     = st_reg.wide_bus;
    assign two_line_out     = st_reg.two_line;
    assign tall_glyph_out   = st_reg.tall_glyph;
    assign shift_ofs_out    = st_reg.shift_ofs;

    // checks on the port's own behaviour
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    chk_exec_sets_busy: assert property (exec |=> st_reg.busy)
        else $error("busy not raised after accepted word");
    chk_write_time: assert property (exec && st_reg.rs_s2 && !st_reg.rw_s2
        |=> st_reg.wait_cnt == 16'(DATA_CYC))
        else $error("data write time wrong");
    chk_clear_fills: assert property (exec && !st_reg.rs_s2 && op == OP_CLEAR
        |=> st_reg.ptr == `ADDR_HOME && st_reg.text_ram[0] == `SPACE_CODE
            && st_reg.wait_cnt == 16'(LONG_CYC))
        else $error("clear did not complete");
    chk_home_resets: assert property (exec && !st_reg.rs_s2 && op == OP_HOME
        |=> st_reg.ptr == `ADDR_HOME && st_reg.shift_ofs == `ADDR_HOME)
        else $error("home did not reset pointer");
    chk_read_steps: assert property (exec && st_reg.rs_s2 && st_reg.rw_s2
        |=> st_reg.ptr == step_ptr($past(st_reg.ptr), st_reg.step_up,
                                   st_reg.two_line, st_reg.glyph_sel))
        else $error("pointer did not step after read");
    chk_status_shows: assert property (rise_edge && st_reg.rw_s2 && !st_reg.rs_s2
        && st_reg.wide_bus |=> st_reg.doe && st_reg.dout == {$past(st_reg.busy),
                                                           $past(st_reg.ptr)})
        else $error("status read wrong");
    chk_first_nibble: assert property (fall_edge && !st_reg.wide_bus
        && !st_reg.second_half && !st_reg.busy |=> !st_reg.busy)
        else $error("busy raised after first nibble");
    chk_width_bit: assert property (exec && !st_reg.rs_s2 && op == OP_FUNC
        |=> st_reg.wide_bus == $past(word[`BIT_BUS_WIDTH]))
        else $error("bus width not taken");
    chk_text_addr: assert property (exec && !st_reg.rs_s2 && op == OP_TEXT_ADDR
        |=> (st_reg.ptr == $past(word[6:0]) && !st_reg.glyph_sel && st_reg.busy)
            ##1 st_reg.busy)
        else $error("text address not loaded");

    // mode bits, screen shift and the nibble order of narrow reads
    chk_entry_bits: assert property (exec && !st_reg.rs_s2 && op == OP_ENTRY
        |=> st_reg.step_up == $past(word[`BIT_STEP_UP])
            && st_reg.scr_shift == $past(word[`BIT_SCR_SHIFT]))
        else $error("entry mode bits not taken");
    chk_display_bits: assert property (exec && !st_reg.rs_s2 && op == OP_DISPLAY
        |=> {st_reg.screen_on, st_reg.cursor_on, st_reg.cursor_blink}
            == $past(word[`BIT_SCREEN_ON:`BIT_BLINK]))
        else $error("display control bits not taken");
    chk_write_shift: assert property (exec && st_reg.rs_s2 && !st_reg.rw_s2
        && !st_reg.glyph_sel && st_reg.scr_shift
        |=> st_reg.shift_ofs == shift_win($past(st_reg.shift_ofs), st_reg.step_up))
        else $error("display did not shift on text write");
    chk_glyph_no_shift: assert property (exec && st_reg.rs_s2 && st_reg.glyph_sel
        |=> $stable(st_reg.shift_ofs))
        else $error("display shifted on glyph access");
    chk_second_nibble: assert property (rise_edge && st_reg.rw_s2 && st_reg.rs_s2
        && !st_reg.wide_bus && st_reg.second_half
        |=> st_reg.dout == {$past(st_reg.read_word[3:0]), 4'h0})
        else $error("second nibble of read word wrong");

    cov_clear: cover property (exec && !st_reg.rs_s2 && op == OP_CLEAR);
    cov_nibble_write: cover property (exec && !st_reg.wide_bus && st_reg.rs_s2);
    cov_data_read: cover property (exec && st_reg.rs_s2 && st_reg.rw_s2);
    cov_refused: cover property (word_done && st_reg.busy && !st_reg.rw_s2);
    cov_narrow_read: cover property (exec && !st_reg.wide_bus && st_reg.rw_s2);
endmodule

// ===== verif/lcd_host.sv
// host processor model that drives the display instruction port
module lcd_host (
    input  wire logic       clk_in,    // bench clock
    output logic            rs_out,    // register select
    output logic            rw_out,    // high reads
    output logic            en_out,    // transfer strobe
    output logic      [7:0] bus_out,   // pin level of the data lines
    input  wire logic [7:0] dev_in,    // value the port drives
    input  wire logic       dev_oe_in  // port drives the lines
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HALF_OSC = 19;      // half an oscillator period in clocks
    logic       wide = 1'b1;           // host view of the bus width
    logic       own  = 1'b0;
    logic [7:0] drv  = 8'h00;
    logic [7:0] last = 8'h00;
    initial begin
        rs_out = 1'b0;
        rw_out = 1'b0;
        en_out = 1'b0;
    end
    // no pull-ups: released lines toggle so a stale value never reads as valid
    always_ff @(posedge clk_in) last <= bus_out;
    assign bus_out = dev_oe_in ? dev_in : (own ? drv : ~last);
    // one strobe; everything held from before the rise until after the fall
    task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
                        output logic [7:0] q);
        rs_out <= rs;
        rw_out <= rw;
        drv    <= d;
        own    <= !rw;
        @(posedge clk_in);
        en_out <= 1'b1;
        repeat (6) @(posedge clk_in);
        q = bus_out;
        en_out <= 1'b0;
        repeat (5) @(posedge clk_in);
        own <= 1'b0;
        // let an edge pass so a following call never assigns own in this step
        @(posedge clk_in);
    endtask
    // a whole word: one strobe when wide, high then low nibble when narrow
    task automatic word(input logic rs, input logic rw, input logic [7:0] w,
                        output logic [7:0] q);
        logic [7:0] a;
        logic [7:0] b;
        if (wide) begin
            xfer(rs, rw, w, q);
        end else begin
            xfer(rs, rw, w, a);
            xfer(rs, rw, {w[3:0], ~w[3:0]}, b);
            q = {a[7:4], b[7:4]};
        end
    endtask
    // poll the flag with a bound, then the settling gap before the next word
    task automatic wait_idle(output logic ok);
        logic [7:0] s;
        ok = 1'b0;
        for (int i = 0; i < 2000 && !ok; i++) begin
            word(1'b0, 1'b1, 8'h00, s);
            ok = (s[7] === 1'b0);
        end
        repeat (HALF_OSC) @(posedge clk_in);
    endtask
endmodule

// ===== verif/char_lcd_instruction_port_tb.sv
// self-checking bench of the display instruction port
module char_lcd_instruction_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LONG = 40;          // shortened clear and home time
    logic       clk_in = 1'b0;
    logic       rst_in = 1'b1;
    logic       rs, rw, en, doe, busy, scr, cur, blk, wide, two, tall;
    logic [7:0] bus, dout, q;
    logic [6:0] ptr, ofs;
    int         error_cnt = 0;
    int         n_checks = 0;
    int         cyc = 0;
    int         run = 0;
    int         blen = 0;

    lcd_port #(.LONG_CYC(LONG)) i_dut (.clk_in(clk_in), .rst_in(rst_in),
        .register_select_in(rs), .read_write_in(rw), .strobe_in(en), .data_in(bus),
        .data_out(dout), .data_oe_out(doe), .busy_out(busy), .ram_pointer_out(ptr),
        .screen_on_out(scr), .cursor_on_out(cur), .cursor_blink_out(blk),
        .wide_bus_out(wide), .two_line_out(two), .tall_glyph_out(tall),
        .shift_ofs_out(ofs));
    lcd_host i_host (.clk_in(clk_in), .rs_out(rs), .rw_out(rw), .en_out(en),
        .bus_out(bus), .dev_in(dout), .dev_oe_in(doe));

    initial begin
        forever #50 clk_in = ~clk_in;
    end
    // cycle ceiling, and length of the latest busy stretch
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        run <= (busy === 1'b1) ? run + 1 : 0;
        if (busy !== 1'b1 && run != 0) blen <= run;
        if (cyc == 90000) begin
            error_cnt++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    // execution time within two clocks of the expected count
    task automatic tim(input int n);
        chk("exec time", 8'h01, {7'h0, blen >= n - 2 && blen <= n + 2});
    endtask
    // one word, then wait until the port is idle again
    task automatic op(input logic r, input logic w, input logic [7:0] d);
        logic ok;
        i_host.word(r, w, d, q);
        i_host.wait_idle(ok);
        chk("idle", 8'h01, {7'h0, ok});
    endtask
    task automatic ins(input logic [7:0] c);
        op(1'b0, 1'b0, c);
    endtask
    task automatic wr(input logic [7:0] d);
        op(1'b1, 1'b0, d);
    endtask
    task automatic rd();
        op(1'b1, 1'b1, 8'h00);
    endtask
    task automatic t_reset();
        chk("flags", 8'h80, {wide, two, tall, scr, cur, blk, busy, 1'b0});
        chk("pointer", 8'h00, {1'h0, ptr});
        i_host.word(1'b0, 1'b1, 8'h00, q);
        chk("status", 8'h00, q);
    endtask
    task automatic t_stale();
        logic ok;
        i_host.word(1'b1, 1'b1, 8'h00, q);
        chk("stale read", 8'h20, q);
        i_host.word(1'b0, 1'b1, 8'h00, q);
        chk("busy status", 8'h81, q);
        i_host.wait_idle(ok);
        tim(430);
        chk("read step", 8'h01, {1'h0, ptr});
    endtask
    task automatic t_write();
        ins(8'h38);
        chk("config", 8'h06, {5'h0, wide, two, tall});
        ins(8'ha7);
        tim(390);
        chk("addr set", 8'h27, {1'h0, ptr});
        wr(8'h41);
        tim(430);
        chk("line wrap", 8'h40, {1'h0, ptr});
        wr(8'h42);
        rd();
        chk("old word", 8'h00, q);
        ins(8'ha7);
        rd();
        chk("read back", 8'h41, q);
        rd();
        chk("read wrap", 8'h42, q);
    endtask
    task automatic t_clear();
        ins(8'h01);
        tim(LONG);
        chk("clear ptr", 8'h00, {1'h0, ptr});
        ins(8'ha7);
        rd();
        chk("space", 8'h20, q);
    endtask
    task automatic t_entry();
        ins(8'h04);
        ins(8'h85);
        wr(8'h5a);
        chk("decrement", 8'h04, {1'h0, ptr});
        ins(8'h14);
        chk("cursor right", 8'h05, {1'h0, ptr});
        rd();
        chk("shift reload", 8'h5a, q);
        ins(8'h18);
        chk("screen shift", 8'h01, {1'h0, ofs});
        chk("ptr kept", 8'h04, {1'h0, ptr});
        ins(8'h07);
        wr(8'h33);
        chk("write shift", 8'h02, {1'h0, ofs});
        ins(8'h02);
        tim(LONG);
        chk("home ofs", 8'h00, {1'h0, ofs});
        chk("home ptr", 8'h00, {1'h0, ptr});
        ins(8'h85);
        rd();
        chk("ram kept", 8'h5a, q);
    endtask
    task automatic t_display();
        for (int i = 0; i < 8; i++) begin
            ins(8'h08 | 8'(i));
            chk("display", 8'(i), {5'h0, scr, cur, blk});
        end
    endtask
    // a second address set while busy is dropped
    task automatic t_ignore();
        logic ok;
        i_host.word(1'b0, 1'b0, 8'h90, q);
        i_host.word(1'b0, 1'b0, 8'hc5, q);
        i_host.wait_idle(ok);
        chk("busy drop", 8'h10, {1'h0, ptr});
    endtask
    task automatic t_narrow();
        logic ok;
        i_host.word(1'b0, 1'b0, 8'h2c, q);
        i_host.wide = 1'b0;
        i_host.wait_idle(ok);
        chk("narrow", 8'h03, {5'h0, wide, two, tall});
        i_host.xfer(1'b0, 1'b0, 8'h78, q);
        chk("busy half", 8'h00, {7'h0, busy});
        i_host.xfer(1'b0, 1'b0, 8'hf0, q);
        chk("busy word", 8'h01, {7'h0, busy});
        i_host.wait_idle(ok);
        chk("glyph ptr", 8'h3f, {1'h0, ptr});
        wr(8'ha5);
        chk("glyph wrap", 8'h00, {1'h0, ptr});
        ins(8'h7f);
        rd();
        chk("glyph read", 8'ha5, q);
    endtask
    initial begin
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        t_reset();
        t_stale();
        t_write();
        t_clear();
        t_entry();
        t_display();
        t_ignore();
        t_narrow();
        end_of_test();
    end
endmodule
